// file: src/route_lookup_regs.vh
// Register offsets, field positions and constants of the route lookup block
`ifndef ROUTE_LOOKUP_REGS_VH
`define ROUTE_LOOKUP_REGS_VH
`define OFS_RT_WRITE      12'h000
`define OFS_RT_WIDX       12'h004
`define OFS_LOCAL_CFG     12'h008
`define OFS_RD_DATA       12'h00c
`define OFS_MC_STAT_L     12'h010
`define OFS_MC_STAT_R     12'h014
`define OFS_MACHINE_CHECK_MISC_L     12'h018
`define OFS_MACHINE_CHECK_MISC_R     12'h01c
`define OFS_IN_ERR_BASE   12'h040
`define OFS_OUT_ERR_BASE  12'h060
`define OFS_EVSEL_A_BASE  12'h080
`define OFS_EVSEL_B_BASE  12'h0a0
`define OFS_PMON_BASE     12'h100
`define WE_VN1            20
`define WE_VN0            19
`define WE_VNA            18
`define RT_ENTRIES        32
`define RT_MAIN           24
`define ENT_VNA_PAR       17
`define ENT_VN1_PAR       9
`define ENT_VN0_PAR       4
`define CFG_BC_ENA        0
`define CFG_SOCK_LO       2
`define CFG_GLOBAL_MATCH  5
`define ERR_SBE           0
`define ERR_POISON        1
`define LOCAL_PAIR0       2'h1
`define LOCAL_CFG_CTRL    2'h2
`define LOCAL_PAIR1       2'h3
`define LOCAL_IOHUB       2'h0
`define BC_BASE           5'h18
`endif

// file: src/router_table_route_lookup.v
// Route table lookup, agent table, error banks, event selection and counters of the router
//
// Contract
// - Snoop with destination bit 0 and broadcast enable reads a broadcast entry.
// - Broadcast lookups serve both adaptive and non-adaptive networks.
// - Agent table indexed by class, opcode, destination bit 1, txn bit 0; one-hot 9-bit.
// - Agent table used only on node match with nonzero low destination bits.
// - Low bits 00 io hub via table, 01 pair 0, 10 config, 11 pair 1.
// - Array holds 24 main plus 8 broadcast entries, 15 data, 3 parity bits.
// - Array has two read ports, lookup and read-back, and one separate write port.
// - Any input port may route to any of the other seven ports.
// - Bits 16:10 adaptive mask, bit 17 its even parity.
// - Bits 7:5 network-one port, bit 8 out network, bit 9 parity.
// - Bits 2:0 network-zero port, bit 3 out network, bit 4 parity.
// - A write updates only subsections whose enables 20, 19, 18 are set.
// - Write register fields are interleaved as the documented bit map.
// - Left bank takes ports 0 to 3, right bank ports 4 to 7.
// - Each port gives 12 events plus 4-bit source; misc records the source.
// - Single-bit ECC corrected, poison uncorrectable, rest fatal; recoverable passes through.
// - Hard machine check for every event except single-bit ECC.
// - Left bank feeds caching agent 0 bank, right bank agent 1 bank.
// - Per-port error logs set directly, independent of machine-check flags.
// - Sixteen counters: 0-7 ports 0-3, 8-15 ports 4-7.
// - Two event-select registers per port feed an OR tree to counters.
// - Warm reset clears outputs, status, logs and counters; cold reset also clears configuration and bus state; neither clears route or agent tables.
// - Table bypassed when global match is enabled, destination bits 4:2 match local socket and 1:0 nonzero.
`timescale 1ns/1ps
`include "route_lookup_regs.vh"
module router_table_route_lookup (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        warm_rst_b,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        lk_valid,
    input  wire [2:0]  lk_in_port,
    input  wire        lk_in_vnet,
    input  wire        lk_snoop,
    input  wire [4:0]  dest_node_id,
    input  wire [1:0]  lk_msg_class,
    input  wire [1:0]  lk_opcode,
    input  wire        request_txn_id,
    output reg         rt_valid,
    output reg  [7:0]  adaptive_route_mask,
    output reg  [2:0]  vnet_zero_port_code,
    output reg         vnet_zero_out_select,
    output reg  [2:0]  vnet_one_port_code,
    output reg         vnet_one_out_select,
    output reg  [8:0]  agent_mask,
    output reg         agent_route,
    output reg         parity_err,
    input  wire [95:0] port_err_events,
    input  wire [31:0] port_error_source_port,
    input  wire        recoverable_in,
    output reg         recoverable_out,
    output reg  [2:0]  bank_left_flags,
    output reg  [2:0]  bank_right_flags,
    output reg         corrected_error_intr,
    output reg         hard_mc,
    input  wire [63:0] port_perf_events
);

function even_par;
    input [6:0] v;
    begin
        even_par = ^v;
    end
endfunction

// Spreads a 7-bit mask over 8 output ports, skipping the input's own port
function [7:0] expand_mask;
    input [6:0] m;
    input [2:0] p;
    integer     i;
    integer     k;
    begin
        expand_mask = 8'h00;
        k = 0;
        for (i = 0; i < 8; i = i + 1) begin
            if (i[2:0] != p) begin
                expand_mask[i] = m[k];
                k = k + 1;
            end
        end
    end
endfunction

reg  [17:0] route_table_array [0:`RT_ENTRIES-1];
reg  [8:0]  agent_table [0:63];
reg  [20:0] route_table_write_port;
reg  [4:0]  wr_index;
reg  [7:0]  local_cfg;
reg  [17:0] rd_back;
reg  [11:0] mc_stat [0:1];
reg  [3:0]  machine_check_misc [0:1];
reg  [15:0] in_err_log [0:7];
reg  [15:0] out_err_log [0:7];
reg  [7:0]  evsel_a [0:7];
reg  [7:0]  evsel_b [0:7];
reg  [31:0] pmon [0:15];
reg         ph_valid;
reg         ph_write;
reg  [11:0] ph_addr;
reg         wr_pending;
reg  [31:0] next_rdata;
integer     n;

wire        cold = ~rst_b;
wire        clr = ~rst_b | ~warm_rst_b;
wire        local_match = local_cfg[`CFG_GLOBAL_MATCH] &&
                          (dest_node_id[4:2] == local_cfg[`CFG_SOCK_LO+2:`CFG_SOCK_LO]);
// Agent path only on match with nonzero low bits
wire        use_agent = local_match && (dest_node_id[1:0] != `LOCAL_IOHUB);
wire        use_bc = lk_snoop && dest_node_id[0] && local_cfg[`CFG_BC_ENA];
wire [4:0]  main_idx = (dest_node_id[4] == 1'b0) ? {2'b00, dest_node_id[3:2], 1'b0} |
                       {4'h0, (dest_node_id[1] | dest_node_id[0])} : dest_node_id - 5'h08;
wire [4:0]  rd_idx = use_bc ? (`BC_BASE + {2'b00, dest_node_id[4:2]}) : main_idx;
wire [17:0] ent = route_table_array[rd_idx];
wire [5:0]  agent_idx = {lk_msg_class, lk_opcode, dest_node_id[1], request_txn_id};

always @(posedge clk) begin
    if (clr) begin
        rt_valid <= 1'b0;
        adaptive_route_mask <= 8'h00;
        vnet_zero_port_code <= 3'h0;
        vnet_zero_out_select <= 1'b0;
        vnet_one_port_code <= 3'h0;
        vnet_one_out_select <= 1'b0;
        agent_mask <= 9'h000;
        agent_route <= 1'b0;
        parity_err <= 1'b0;
    end else begin
        rt_valid <= lk_valid;
        agent_route <= lk_valid & use_agent;
        // Mask stays clear between lookups so it never stands without agent_route
        agent_mask <= (lk_valid & use_agent) ? agent_table[agent_idx] : 9'h000;
        adaptive_route_mask <= expand_mask(ent[16:10], lk_in_port);
        vnet_zero_port_code <= ent[2:0];
        vnet_zero_out_select <= ent[3];
        vnet_one_port_code <= ent[7:5];
        vnet_one_out_select <= ent[8];
        parity_err <= lk_valid & ~use_agent &
                      ((even_par(ent[16:10]) != ent[`ENT_VNA_PAR]) ||
                       (lk_in_vnet ? (even_par({3'h0, ent[8:5]}) != ent[`ENT_VN1_PAR])
                                   : (even_par({3'h0, ent[3:0]}) != ent[`ENT_VN0_PAR])));
    end
end

// Separate write port with subsection enables
always @(posedge clk) begin
    // Other registers share the write-port latch; only its own offset may touch the array
    if (wr_pending && ph_addr == `OFS_RT_WRITE) begin
        if (route_table_write_port[`WE_VNA])
            route_table_array[wr_index][17:10] <= {route_table_write_port[15],
                route_table_write_port[12], route_table_write_port[10],
                route_table_write_port[8], route_table_write_port[6],
                route_table_write_port[5], route_table_write_port[3],
                route_table_write_port[1]};
        if (route_table_write_port[`WE_VN1])
            route_table_array[wr_index][9:5] <= {route_table_write_port[17],
                route_table_write_port[7], route_table_write_port[4],
                route_table_write_port[2], route_table_write_port[0]};
        if (route_table_write_port[`WE_VN0])
            route_table_array[wr_index][4:0] <= {route_table_write_port[16],
                route_table_write_port[14], route_table_write_port[13],
                route_table_write_port[11], route_table_write_port[9]};
    end
end

reg  [11:0] ev_l;
reg  [11:0] ev_r;
reg  [3:0]  src_l;
reg  [3:0]  src_r;
always @* begin
    ev_l = 12'h000;
    ev_r = 12'h000;
    src_l = 4'h0;
    src_r = 4'h0;
    for (n = 0; n < 4; n = n + 1) begin
        ev_l = ev_l | port_err_events[n*12 +: 12];
        ev_r = ev_r | port_err_events[(n+4)*12 +: 12];
        if (|port_err_events[n*12 +: 12])
            src_l = src_l | port_error_source_port[n*4 +: 4];
        if (|port_err_events[(n+4)*12 +: 12])
            src_r = src_r | port_error_source_port[(n+4)*4 +: 4];
    end
end

always @(posedge clk) begin
    if (clr) begin
        recoverable_out <= 1'b0;
        bank_left_flags <= 3'h0;
        bank_right_flags <= 3'h0;
        corrected_error_intr <= 1'b0;
        hard_mc <= 1'b0;
        mc_stat[0] <= 12'h000;
        mc_stat[1] <= 12'h000;
        machine_check_misc[0] <= 4'h0;
        machine_check_misc[1] <= 4'h0;
    end else begin
        recoverable_out <= recoverable_in;
        // Flags: {fatal, uncorrectable, corrected}
        bank_left_flags <= {|(ev_l & ~12'h003), ev_l[`ERR_POISON], ev_l[`ERR_SBE]};
        bank_right_flags <= {|(ev_r & ~12'h003), ev_r[`ERR_POISON], ev_r[`ERR_SBE]};
        corrected_error_intr <= ev_l[`ERR_SBE] | ev_r[`ERR_SBE];
        hard_mc <= |(ev_l & ~12'h001) | |(ev_r & ~12'h001);
        // Sticky status; set wins over a software clear in the same cycle
        mc_stat[0] <= mc_stat[0] | ev_l;
        mc_stat[1] <= mc_stat[1] | ev_r;
        if (|ev_l)
            machine_check_misc[0] <= src_l;
        if (|ev_r)
            machine_check_misc[1] <= src_r;
        if (wr_pending && ph_addr == `OFS_MC_STAT_L)
            mc_stat[0] <= ev_l;
        if (wr_pending && ph_addr == `OFS_MC_STAT_R)
            mc_stat[1] <= ev_r;
    end
end

always @(posedge clk) begin
    for (n = 0; n < 8; n = n + 1) begin
        if (clr) begin
            in_err_log[n] <= 16'h0000;
            out_err_log[n] <= 16'h0000;
        end else if (wr_pending && ph_addr == (`OFS_IN_ERR_BASE + n*4)) begin
            in_err_log[n] <= {10'h000, port_err_events[n*12+2 +: 6]};
        end else if (wr_pending && ph_addr == (`OFS_OUT_ERR_BASE + n*4)) begin
            out_err_log[n] <= {14'h0000, port_err_events[n*12 +: 2]};
        end else begin
            in_err_log[n] <= in_err_log[n] | {10'h000, port_err_events[n*12+2 +: 6]};
            out_err_log[n] <= out_err_log[n] | {14'h0000, port_err_events[n*12 +: 2]};
        end
        if (cold) begin
            evsel_a[n] <= 8'h00;
            evsel_b[n] <= 8'h00;
        end else if (wr_pending && ph_addr == (`OFS_EVSEL_A_BASE + n*4)) begin
            evsel_a[n] <= route_table_write_port[7:0];
        end else if (wr_pending && ph_addr == (`OFS_EVSEL_B_BASE + n*4)) begin
            evsel_b[n] <= route_table_write_port[7:0];
        end
    end
    // Each port pair of counters: set 2p from select a, 2p+1 from select b
    for (n = 0; n < 16; n = n + 1) begin
        if (clr)
            pmon[n] <= 32'h00000000;
        else if (n[0] == 1'b0 && |(evsel_a[n/2] & port_perf_events[(n/2)*8 +: 8]))
            pmon[n] <= pmon[n] + 32'h00000001;
        else if (n[0] == 1'b1 && |(evsel_b[n/2] & port_perf_events[(n/2)*8 +: 8]))
            pmon[n] <= pmon[n] + 32'h00000001;
    end
end

// Agent table is configuration, kept across warm reset
always @(posedge clk) begin
    if (wr_pending && ph_addr[11:8] == 4'h2)
        agent_table[ph_addr[7:2]] <= route_table_write_port[8:0];
end

// AHB-Lite slave, zero wait states; index and local config writes land at the end of the data phase, others one cycle after
always @* begin
    next_rdata = 32'h00000000;
    case (haddr)
        `OFS_RT_WIDX:   next_rdata = {27'h0, wr_index};
        `OFS_LOCAL_CFG: next_rdata = {24'h0, local_cfg};
        `OFS_RD_DATA:   next_rdata = {14'h0, rd_back};
        `OFS_MC_STAT_L: next_rdata = {20'h0, mc_stat[0]};
        `OFS_MC_STAT_R: next_rdata = {20'h0, mc_stat[1]};
        `OFS_MACHINE_CHECK_MISC_L: next_rdata = {28'h0, machine_check_misc[0]};
        `OFS_MACHINE_CHECK_MISC_R: next_rdata = {28'h0, machine_check_misc[1]};
        default: begin
            if (haddr[11:5] == 7'h02)
                next_rdata = {16'h0, in_err_log[haddr[4:2]]};
            else if (haddr[11:5] == 7'h03)
                next_rdata = {16'h0, out_err_log[haddr[4:2]]};
            else if (haddr[11:5] == 7'h04)
                next_rdata = {24'h0, evsel_a[haddr[4:2]]};
            else if (haddr[11:5] == 7'h05)
                next_rdata = {24'h0, evsel_b[haddr[4:2]]};
            else if (haddr[11:6] == 6'h04)
                next_rdata = pmon[haddr[5:2]];
        end
    endcase
end

always @(posedge clk) begin
    if (cold) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        ph_valid <= 1'b0;
        ph_write <= 1'b0;
        ph_addr <= 12'h000;
        wr_pending <= 1'b0;
        route_table_write_port <= 21'h000000;
        wr_index <= 5'h00;
        local_cfg <= 8'h00;
        rd_back <= 18'h00000;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        ph_valid <= hsel & htrans[1] & hready;
        ph_write <= hwrite;
        if (hsel & htrans[1] & hready)
            ph_addr <= haddr;
        hrdata <= (hsel & htrans[1] & hready & ~hwrite) ? next_rdata : 32'h00000000;
        wr_pending <= ph_valid & ph_write;
        if (ph_valid & ph_write)
            route_table_write_port <= hwdata[20:0];
        if (ph_valid & ph_write && ph_addr == `OFS_RT_WIDX)
            wr_index <= hwdata[4:0];
        if (ph_valid & ph_write && ph_addr == `OFS_LOCAL_CFG)
            local_cfg <= hwdata[7:0];
        // Read-back trails the array by one cycle; software must not read
        // the entry in the cycle right after its write lands
        rd_back <= route_table_array[wr_index];
    end
end

endmodule

// file: sim/router_table_route_lookup_chk.sv
// Checker on the route lookup ports
`timescale 1ns/1ps
module route_lookup_chk (
    input wire        clk,
    input wire        rst_b,
    input wire        warm_rst_b,
    input wire        lk_valid,
    input wire [2:0]  lk_in_port,
    input wire [4:0]  dest_node_id,
    input wire        rt_valid,
    input wire [7:0]  adaptive_route_mask,
    input wire [8:0]  agent_mask,
    input wire        agent_route,
    input wire [95:0] port_err_events,
    input wire        recoverable_in,
    input wire        recoverable_out,
    input wire [2:0]  bank_left_flags,
    input wire [2:0]  bank_right_flags,
    input wire        corrected_error_intr,
    input wire        hard_mc
);
    // Bank class {fatal, uncorrectable, corrected} over four ports
    function [2:0] cls(input [47:0] ev);
        integer i;
        begin
            cls = 3'h0;
            for (i = 0; i < 4; i = i + 1)
                cls = cls | {|ev[12*i+2 +: 10], ev[12*i+1], ev[12*i]};
        end
    endfunction
    wire [2:0] lc = cls(port_err_events[47:0]);
    wire [2:0] rc = cls(port_err_events[95:48]);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_LEFT_BANK: assert property (warm_rst_b |=> bank_left_flags == $past(lc))
        else $error("left bank flags wrong");
    AST_RIGHT_BANK: assert property (warm_rst_b |=> bank_right_flags == $past(rc))
        else $error("right bank flags wrong");
    AST_CORR_INTR: assert property (warm_rst_b |=>
        corrected_error_intr == $past(lc[0] | rc[0])) else $error("corrected intr wrong");
    AST_HARD_MC: assert property (warm_rst_b |=>
        hard_mc == $past(|{lc[2:1], rc[2:1]})) else $error("hard machine check wrong");
    AST_RECOV_PASS: assert property (warm_rst_b |=>
        recoverable_out == $past(recoverable_in)) else $error("recoverable not passed");
    AST_AGENT_ONEHOT: assert property (
        agent_route ? $onehot(agent_mask) : agent_mask == 9'h0) else $error("agent mask");
    AST_AGENT_CAUSE: assert property (agent_route |->
        $past(lk_valid) && $past(dest_node_id[1:0]) != 2'h0) else $error("agent cause");
    AST_LOOKUP_LAT: assert property (warm_rst_b |=> rt_valid == $past(lk_valid))
        else $error("lookup answer late");
    AST_NO_UTURN: assert property (rt_valid |->
        !adaptive_route_mask[$past(lk_in_port)]) else $error("route back to input");
endmodule
bind router_table_route_lookup route_lookup_chk u_chk (.clk, .rst_b, .warm_rst_b,
    .lk_valid, .lk_in_port, .dest_node_id, .rt_valid, .adaptive_route_mask, .agent_mask,
    .agent_route, .port_err_events, .recoverable_in, .recoverable_out, .bank_left_flags,
    .bank_right_flags, .corrected_error_intr, .hard_mc);

// file: sim/port_agents.sv
// Far-side model: ports and agents raising error and performance events
`timescale 1ns/1ps
module port_agents (
    input  wire        clk,
    input  wire        err_fire,
    input  wire [2:0]  err_port,
    input  wire [3:0]  err_bit,
    input  wire [3:0]  error_source_port,
    input  wire        perf_on,
    input  wire [5:0]  perf_sel,
    input  wire        recov,
    output reg  [95:0] port_err_events = 96'h0,
    output reg  [31:0] port_error_source_port = 32'h0,
    output reg  [63:0] port_perf_events = 64'h0,
    output reg         recoverable_in = 1'b0
);
    always @(posedge clk) begin
        port_err_events <= 96'h0;
        port_error_source_port <= 32'h0;
        if (err_fire) begin
            port_err_events[12*err_port+err_bit] <= 1'b1;
            port_error_source_port[4*err_port +: 4] <= error_source_port;
        end
        port_perf_events <= perf_on ? 64'h1 << perf_sel : 64'h0;
        recoverable_in <= recov;
    end
endmodule

// file: sim/tb_router_table_route_lookup.sv
// Self-checking bench for the route lookup block
`timescale 1ns/1ps
`include "route_lookup_regs.vh"
module tb_router_table_route_lookup;
    logic        clk = 1'b0, rst_b = 1'b0, warm_rst_b = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0]  htrans = 2'h0, lk_msg_class = 2'h0, lk_opcode = 2'h0;
    logic [2:0]  hsize = 3'h2, lk_in_port = 3'h0, err_port = 3'h0;
    logic [31:0] hwdata = 32'h0, rdv;
    logic        lk_valid = 1'b0, lk_in_vnet = 1'b0, lk_snoop = 1'b0, request_txn_id = 1'b0;
    logic [4:0]  dest_node_id = 5'h0;
    logic        err_fire = 1'b0, perf_on = 1'b0, recov = 1'b0;
    logic [3:0]  err_bit = 4'h0, error_source_port = 4'h0;
    logic [5:0]  perf_sel = 6'h0;
    wire  [31:0] hrdata, port_error_source_port;
    wire         hreadyout, hresp, rt_valid, agent_route, parity_err, recoverable_out;
    wire         vnet_zero_out_select, vnet_one_out_select, corrected_error_intr, hard_mc;
    wire  [2:0]  vnet_zero_port_code, vnet_one_port_code, bank_left_flags, bank_right_flags;
    wire  [7:0]  adaptive_route_mask;
    wire  [8:0]  agent_mask;
    wire  [95:0] port_err_events;
    wire  [63:0] port_perf_events;
    wire         recoverable_in;
    wire         hready = hreadyout;
    int          rt [0:31];
    int          failures = 0, n_tests = 0, cycles = 0, i, k, e;
    integer      seed = 32'hb7f4;
    logic [8:0]  am;
    logic [4:0]  d;
    logic        s, v;
    router_table_route_lookup u_dut (.clk, .rst_b, .warm_rst_b, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .lk_valid,
        .lk_in_port, .lk_in_vnet, .lk_snoop, .dest_node_id, .lk_msg_class, .lk_opcode,
        .request_txn_id, .rt_valid, .adaptive_route_mask, .vnet_zero_port_code,
        .vnet_zero_out_select, .vnet_one_port_code, .vnet_one_out_select, .agent_mask,
        .agent_route, .parity_err, .port_err_events, .port_error_source_port, .recoverable_in,
        .recoverable_out, .bank_left_flags, .bank_right_flags, .corrected_error_intr,
        .hard_mc, .port_perf_events);
    port_agents u_far (.clk, .err_fire, .err_port, .err_bit, .error_source_port, .perf_on,
        .perf_sel, .recov, .port_err_events, .port_error_source_port, .port_perf_events,
        .recoverable_in);
    initial forever #2.5 clk = ~clk;
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            conclude;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single transfer; waits on hready in both phases
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task put(input int idx, input logic [20:0] w);
        bus(1'b1, `OFS_RT_WIDX, idx);
        bus(1'b1, `OFS_RT_WRITE, {11'h0, w});
        repeat (2) @(posedge clk);
        if (w[18]) rt[idx][17:10] = {w[15], w[12], w[10], w[8], w[6], w[5], w[3], w[1]};
        if (w[20]) rt[idx][9:5] = {w[17], w[7], w[4], w[2], w[0]};
        if (w[19]) rt[idx][4:0] = {w[16], w[14], w[13], w[11], w[9]};
    endtask
    // Writes carry even parity so the stored entry stays consistent
    function automatic logic [20:0] fixpar(input logic [20:0] w);
        fixpar = w;
        fixpar[15] = ^{w[12], w[10], w[8], w[6], w[5], w[3], w[1]};
        fixpar[16] = ^{w[14], w[13], w[11], w[9]};
        fixpar[17] = ^{w[7], w[4], w[2], w[0]};
    endfunction
    function automatic int index_of(input logic [4:0] x, input logic sn, bc);
        if (sn && x[0] && bc) return 24 + x[4:2];
        if (x[4]) return x - 8;
        return {x[4:2], x[1] | x[0]};
    endfunction
    task look(input logic [2:0] p, input logic vn, sn, input logic [4:0] x);
        lk_valid <= 1'b1;
        lk_in_port <= p;
        lk_in_vnet <= vn;
        lk_snoop <= sn;
        dest_node_id <= x;
        @(posedge clk);
        lk_valid <= 1'b0;
        @(posedge clk);
    endtask
    task count_ev(input int sel, input int n);
        perf_sel <= sel;
        perf_on <= 1'b1;
        repeat (n) @(posedge clk);
        perf_on <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 32; i++) put(i, fixpar($random(seed)) | 21'h1c0000);
        for (i = 0; i < 16; i++) begin
            k = $unsigned($random(seed)) % 32;
            put(k, {i[2:0], 18'h0} | (fixpar($random(seed)) & 21'h3ffff));
            bus(1'b0, `OFS_RD_DATA, 32'h0);
            chk(rdv, rt[k]);
        end
        for (i = 0; i < 24; i++) begin
            bus(1'b1, `OFS_LOCAL_CFG, 32'h1c | i[0]);
            d = ($unsigned($random(seed)) % 28) | i[2];
            v = $random(seed);
            look($random(seed), v, i[1], d);
            e = rt[index_of(d, i[1], i[0])];
            chk(v ? {vnet_one_out_select, vnet_one_port_code} : {vnet_zero_out_select,
                vnet_zero_port_code}, v ? e[8:5] : e[3:0]);
            chk(parity_err, 1'b0);
        end
        put(0, 21'h090000);
        look(3'h1, 1'b0, 1'b0, 5'h0);
        chk(parity_err, 1'b1);
        bus(1'b1, `OFS_LOCAL_CFG, 32'h2c);
        for (i = 0; i < 4; i++) begin
            lk_msg_class <= $random(seed);
            lk_opcode <= $random(seed);
            request_txn_id <= $random(seed);
            am = 9'h1 << ($unsigned($random(seed)) % 9);
            @(posedge clk);
            k = {lk_msg_class, lk_opcode, i[1], request_txn_id};
            bus(1'b1, 12'(12'h200 + 4 * k), {23'h0, am});
            @(posedge clk);
            look(3'h2, 1'b0, 1'b0, {3'h3, i[1:0]});
            chk({agent_route, agent_mask}, i[1:0] == 0 ? 0 : {1'b1, am});
        end
        for (i = 0; i < 8; i++) begin
            err_port <= i;
            err_bit <= (i * 5) % 12;
            error_source_port <= $random(seed);
            recov <= i[0];
            err_fire <= 1'b1;
            @(posedge clk);
            err_fire <= 1'b0;
            repeat (3) @(posedge clk);
            bus(1'b0, i < 4 ? `OFS_MACHINE_CHECK_MISC_L : `OFS_MACHINE_CHECK_MISC_R, 32'h0);
            chk(rdv[3:0], error_source_port);
        end
        bus(1'b0, `OFS_MC_STAT_L, 32'h0);
        chk(rdv, 32'h429);
        bus(1'b0, `OFS_MC_STAT_R, 32'h0);
        chk(rdv, 32'h942);
        for (i = 0; i < 8; i += 5) begin
            bus(1'b1, 12'(`OFS_EVSEL_A_BASE + 4 * i), 32'h1 << i);
            bus(1'b1, 12'(`OFS_EVSEL_B_BASE + 4 * i), 32'h80);
            count_ev(9 * i, i + 3);
            bus(1'b0, 12'(`OFS_PMON_BASE + 8 * i), 32'h0);
            chk(rdv, i + 3);
            bus(1'b0, 12'(`OFS_PMON_BASE + 8 * i + 4), 32'h0);
            chk(rdv, 0);
        end
        warm_rst_b <= 1'b0;
        @(posedge clk);
        warm_rst_b <= 1'b1;
        bus(1'b0, 12'h128, 32'h0);
        chk(rdv, 0);
        count_ev(45, 2);
        bus(1'b0, 12'h128, 32'h0);
        chk(rdv, 2);
        bus(1'b0, 12'h7f0, 32'h0);
        chk(rdv, 0);
        conclude;
    end
endmodule
